/* hw/dgp_pkg.sv */
package dgp_pkg;
    // ==========================================================
    // Register indices (word indices from address bits 9:2; byte offset is index times four)
    localparam logic [7:0] DGP_IDX_P1_DATA = 8'h27;
    localparam logic [7:0] DGP_IDX_P1_DIR = 8'h28;
    localparam logic [7:0] DGP_IDX_P2_DATA = 8'h29;
    localparam logic [7:0] DGP_IDX_P2_DIR = 8'h2a;
    localparam logic [7:0] DGP_IDX_ANA_EN = 8'h2d;
    localparam logic [7:0] DGP_IDX_CMP_EN = 8'h59;
    localparam logic [7:0] DGP_IDX_BITOP = 8'h60;
    // ==========================================================
    // Field layout and reset values
    localparam int DGP_P1_IN_ONLY_BIT = 4;
    localparam int DGP_P2_ANA_BIT = 0;
    localparam logic [2:0] DGP_P2_IMPL_MASK = 3'h7;
    localparam logic [7:0] DGP_DIR_RST = 8'h00;
    localparam logic [7:0] DGP_ENABLE_RST = 8'hff;
    localparam logic [7:0] DGP_LATCH_RST = 8'h00;
    localparam logic [4:0] DGP_UNIMPL_READ = 5'h00;
    localparam logic DGP_STANDBY_IN_LEVEL = 1'b0;
    // Bit operation register fields
    localparam int DGP_BITOP_SET = 7;
    localparam int DGP_BITOP_PORT = 3;
    // ==========================================================
    // Pin group carriers
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } dgp_p1_pins_s;
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } dgp_p2_pins_s;
endpackage

/* hw/dgp_port_pair.sv */
`timescale 1ns/1ps
// Behaviour
// - Direction one drives pin, zero floats it
// - Data reads return pin levels
// - Bit set/clear modify latch, not pins
// - Data writes update latch only when byte lane zero is selected
// - Input bits: latch only, pin floats
// - Reset clears all direction bits
// - Latches undefined at reset; write first
// - Enable bits reset to one
// - Analog enable blocks digital input
// - Comparator enable blocks digital input
// - Standby float forces every driver off
// - Standby holds inputs except input-only pin
// - Port one bit four input-only
// - Port two implements bits zero-two only
// - Converter output overrides port two bits one-two
module dgp_port_pair (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [9:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic standby_pin_float_in,
    input wire logic [1:0] dac_enable_in,
    input wire logic [1:0] dac_value_in,
    input wire logic [7:0] p1_pin_in,
    input wire logic [2:0] p2_pin_in,
    output dgp_pkg::dgp_p1_pins_s p1_pins_out,
    output dgp_pkg::dgp_p2_pins_s p2_pins_out,
    output logic [7:0] p1_digital_in_out,
    output logic [2:0] p2_digital_in_out
);
    import dgp_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [7:0] p1_meta;
    logic [7:0] p1_sync;
    logic [2:0] p2_meta;
    logic [2:0] p2_sync;
    logic stby_meta;
    logic stby_sync;
    logic [1:0] dac_en_meta;
    logic [1:0] dac_en_sync;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            p1_meta <= 8'h00;
            p1_sync <= 8'h00;
            p2_meta <= 3'h0;
            p2_sync <= 3'h0;
            stby_meta <= 1'b0;
            stby_sync <= 1'b0;
            dac_en_meta <= 2'h0;
            dac_en_sync <= 2'h0;
        end
        else
        begin
            p1_meta <= p1_pin_in;
            p1_sync <= p1_meta;
            p2_meta <= p2_pin_in;
            p2_sync <= p2_meta;
            stby_meta <= standby_pin_float_in;
            stby_sync <= stby_meta;
            dac_en_meta <= dac_enable_in;
            dac_en_sync <= dac_en_meta;
        end
    end

    // ==========================================================
    // Register file
    logic [7:0] port_one_data_latch;
    logic [7:0] port_one_direction;
    logic [2:0] port_two_data_latch;
    logic [2:0] port_two_direction;
    logic [7:0] analog_input_enable;
    logic [7:0] comparator_input_enable;

    wire [7:0] reg_idx = wb_adr_in[9:2];
    wire bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire wr_lane = bus_req && wb_we_in && wb_sel_in[0];
    wire wr_p1_data = wr_lane && (reg_idx == DGP_IDX_P1_DATA);
    wire wr_p1_dir = wr_lane && (reg_idx == DGP_IDX_P1_DIR);
    wire wr_p2_data = wr_lane && (reg_idx == DGP_IDX_P2_DATA);
    wire wr_p2_dir = wr_lane && (reg_idx == DGP_IDX_P2_DIR);
    wire wr_ana = wr_lane && (reg_idx == DGP_IDX_ANA_EN);
    wire wr_cmp = wr_lane && (reg_idx == DGP_IDX_CMP_EN);
    wire wr_bitop = wr_lane && (reg_idx == DGP_IDX_BITOP);

    // Bit operation: bit 7 set/clear, bit 3 port, bits 2:0 bit number
    wire bitop_set = wb_dat_in[DGP_BITOP_SET];
    wire bitop_port2 = wb_dat_in[DGP_BITOP_PORT];
    wire [7:0] bitop_mask = 8'h01 << wb_dat_in[2:0];
    // Works from latch values so pins configured as inputs keep their latch
    wire [7:0] p1_bitop_val = bitop_set ? (port_one_data_latch | bitop_mask)
        : (port_one_data_latch & ~bitop_mask);
    wire [2:0] p2_bitop_val = bitop_set ? (port_two_data_latch | bitop_mask[2:0])
        : (port_two_data_latch & ~bitop_mask[2:0]);

    wire [7:0] next_p1_latch = wr_p1_data ? wb_dat_in[7:0]
        : ((wr_bitop && !bitop_port2) ? p1_bitop_val : port_one_data_latch);
    wire [2:0] next_p2_latch = wr_p2_data ? wb_dat_in[2:0]
        : ((wr_bitop && bitop_port2) ? p2_bitop_val : port_two_data_latch);

    // Latches carry no meaningful reset value; cleared only for determinism
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            port_one_data_latch <= DGP_LATCH_RST;
            port_two_data_latch <= DGP_LATCH_RST[2:0];
        end
        else
        begin
            port_one_data_latch <= next_p1_latch;
            port_two_data_latch <= next_p2_latch;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            port_one_direction <= DGP_DIR_RST;
            port_two_direction <= DGP_DIR_RST[2:0];
            analog_input_enable <= DGP_ENABLE_RST;
            comparator_input_enable <= DGP_ENABLE_RST;
        end
        else
        begin
            if (wr_p1_dir)
                port_one_direction <= wb_dat_in[7:0];
            if (wr_p2_dir)
                port_two_direction <= wb_dat_in[2:0] & DGP_P2_IMPL_MASK;
            if (wr_ana)
                analog_input_enable <= wb_dat_in[7:0];
            if (wr_cmp)
                comparator_input_enable <= wb_dat_in[7:0];
        end
    end

    // ==========================================================
    // Pin drive
    // Bit four has no driver at all; its direction bit is storage only
    wire [7:0] p1_in_only = 8'h01 << DGP_P1_IN_ONLY_BIT;
    wire [7:0] next_p1_oe = stby_sync ? 8'h00
        : (port_one_direction & ~p1_in_only);
    wire [7:0] next_p1_out = port_one_data_latch & next_p1_oe;
    wire [2:0] dac_bits = {dac_en_sync, 1'b0};
    wire [2:0] dac_vals = {dac_value_in, 1'b0};
    wire [2:0] next_p2_oe = stby_sync ? 3'h0
        : (port_two_direction | dac_bits);
    wire [2:0] next_p2_out = (dac_bits & dac_vals)
        | (~dac_bits & port_two_data_latch & next_p2_oe);

    // ==========================================================
    // Digital input gating
    // Blocking the buffer avoids crowbar current on mid-rail analog levels
    wire [7:0] p1_block = analog_input_enable | comparator_input_enable;
    wire p2_block0 = analog_input_enable[DGP_P2_ANA_BIT];
    wire [7:0] p1_hold = stby_sync ? ~p1_in_only : 8'h00;
    wire [7:0] next_p1_dig = (p1_sync & ~p1_block & ~p1_hold)
        | ({8{DGP_STANDBY_IN_LEVEL}} & p1_hold);
    wire [2:0] p2_mask = {2'b00, p2_block0} | (stby_sync ? 3'h7 : 3'h0);
    wire [2:0] next_p2_dig = p2_sync & ~p2_mask;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            p1_pins_out <= '0;
            p2_pins_out <= '0;
            p1_digital_in_out <= 8'h00;
            p2_digital_in_out <= 3'h0;
        end
        else
        begin
            p1_pins_out <= '{out: next_p1_out, oe: next_p1_oe};
            p2_pins_out <= '{out: next_p2_out, oe: next_p2_oe};
            p1_digital_in_out <= next_p1_dig;
            p2_digital_in_out <= next_p2_dig;
        end
    end

    // ==========================================================
    // Read path and acknowledge
    wire [7:0] rd_p2_data = {DGP_UNIMPL_READ, p2_sync};
    wire [7:0] rd_p2_dir = {DGP_UNIMPL_READ, port_two_direction};
    wire [7:0] rd_sel =
        (reg_idx == DGP_IDX_P1_DATA) ? p1_sync :
        (reg_idx == DGP_IDX_P1_DIR) ? port_one_direction :
        (reg_idx == DGP_IDX_P2_DATA) ? rd_p2_data :
        (reg_idx == DGP_IDX_P2_DIR) ? rd_p2_dir :
        (reg_idx == DGP_IDX_ANA_EN) ? analog_input_enable :
        (reg_idx == DGP_IDX_CMP_EN) ? comparator_input_enable : 8'h00;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h00000000;
        end
        else
        begin
            wb_ack_out <= bus_req;
            wb_dat_out <= (bus_req && !wb_we_in) ? {24'h000000, rd_sel} : 32'h00000000;
        end
    end

    // ==========================================================
    // Checks
    dir_reset_a: assert property (@(posedge clk_in)
        $rose(rst_n_in) |-> (port_one_direction == DGP_DIR_RST
        && port_two_direction == DGP_DIR_RST[2:0]))
        else $error("direction not cleared by reset");
    enable_reset_a: assert property (@(posedge clk_in)
        $rose(rst_n_in) |-> (analog_input_enable == DGP_ENABLE_RST
        && comparator_input_enable == DGP_ENABLE_RST))
        else $error("input enables not set by reset");
    dir_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_p1_dir |=> port_one_direction == $past(wb_dat_in[7:0]))
        else $error("direction write lost");
    ana_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_ana |=> analog_input_enable == $past(wb_dat_in[7:0]))
        else $error("analog enable write lost");
    cmp_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_cmp |=> comparator_input_enable == $past(wb_dat_in[7:0]))
        else $error("comparator enable write lost");
    latch_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_p1_data |=> port_one_data_latch == $past(wb_dat_in[7:0]))
        else $error("latch not updated by write");
    p2_latch_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_p2_data |=> port_two_data_latch == $past(wb_dat_in[2:0]))
        else $error("port two latch not updated by write");
    bitop_keep_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wr_bitop && !bitop_port2) |=>
        ((port_one_data_latch ^ $past(port_one_data_latch)) & ~$past(bitop_mask)) == 8'h00)
        else $error("bit operation touched other latch bits");
    bitop_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wr_bitop && !bitop_port2 && bitop_set) |=>
        (port_one_data_latch & $past(bitop_mask)) == $past(bitop_mask))
        else $error("bit set did not reach latch");
    read_pin_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (bus_req && !wb_we_in && reg_idx == DGP_IDX_P1_DATA) |=>
        (wb_ack_out && wb_dat_out[7:0] == $past(p1_sync)))
        else $error("data read not pin level");
    read_p2_pin_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (bus_req && !wb_we_in && reg_idx == DGP_IDX_P2_DATA) |=>
        (wb_ack_out && wb_dat_out[2:0] == $past(p2_sync)))
        else $error("port two data read not pin level");
    p2_upper_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wb_ack_out |-> wb_dat_out[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    p2_dir_upper_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (bus_req && !wb_we_in && reg_idx == DGP_IDX_P2_DIR) |=>
        wb_dat_out[7:3] == DGP_UNIMPL_READ)
        else $error("unimplemented direction bits not constant");

    // ==========================================================
    // Checks: pins
    standby_float_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        stby_sync |=> (p1_pins_out.oe == 8'h00 && p2_pins_out.oe == 3'h0))
        else $error("driver on during standby float");
    in_only_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        p1_pins_out.oe[DGP_P1_IN_ONLY_BIT] == 1'b0)
        else $error("input-only pin driven");
    dir_drive_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) (!stby_sync && port_one_direction[0]) |=>
        (p1_pins_out.oe[0] && p1_pins_out.out[0] == $past(port_one_data_latch[0])))
        else $error("output bit not driven from latch");
    p2_drive_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) (!stby_sync && port_two_direction[0]) |=>
        (p2_pins_out.oe[0] && p2_pins_out.out[0] == $past(port_two_data_latch[0])))
        else $error("port two output bit not driven from latch");
    input_float_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !port_one_direction[1] |=> !p1_pins_out.oe[1])
        else $error("input bit driven");
    p2_float_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !port_two_direction[0] |=> !p2_pins_out.oe[0])
        else $error("port two input bit driven");
    block_in_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (analog_input_enable[5] && !stby_sync) |=> p1_digital_in_out[5] == 1'b0)
        else $error("digital input not blocked");
    cmp_block_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (comparator_input_enable[7] && !stby_sync) |=> !p1_digital_in_out[7])
        else $error("digital input not blocked by comparator enable");
    p2_ana_block_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        analog_input_enable[DGP_P2_ANA_BIT] |=> !p2_digital_in_out[DGP_P2_ANA_BIT])
        else $error("port two digital input not blocked");
    standby_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        stby_sync |=> (p1_digital_in_out & ~p1_in_only)
        == ({8{DGP_STANDBY_IN_LEVEL}} & ~p1_in_only))
        else $error("digital inputs not held in standby");
    in_only_pass_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        (!analog_input_enable[DGP_P1_IN_ONLY_BIT] && !comparator_input_enable[DGP_P1_IN_ONLY_BIT])
        |=> p1_digital_in_out[DGP_P1_IN_ONLY_BIT] == $past(p1_sync[DGP_P1_IN_ONLY_BIT]))
        else $error("input-only pin not passed to peripherals");
    dac_prio_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (dac_en_sync[0] && !stby_sync) |=> p2_pins_out.oe[1])
        else $error("converter output not driving");
    dac_value_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (dac_en_sync[1] && !stby_sync) |=>
        p2_pins_out.out[2] == $past(dac_value_in[1]))
        else $error("converter value not on pin");
    write_cov_c: cover property (@(posedge clk_in) wr_p1_data);
    bitop_cov_c: cover property (@(posedge clk_in) wr_bitop && bitop_port2);
    stby_cov_c: cover property (@(posedge clk_in) stby_sync && port_one_direction != 8'h00);
    dac_cov_c: cover property (@(posedge clk_in) dac_en_sync != 2'h0);
    ana_cov_c: cover property (@(posedge clk_in) analog_input_enable[0] && p2_sync[0]);
endmodule

/* tb/dgp_pin_model.sv */
`timescale 1ns/1ps
// ==========
// External pins
module dgp_pin_model
    import dgp_pkg::*;
(
    input wire dgp_pkg::dgp_p1_pins_s p1_pins_in,
    input wire dgp_pkg::dgp_p2_pins_s p2_pins_in,
    input wire logic [7:0] p1_ext_in,
    input wire logic [2:0] p2_ext_in,
    output logic [7:0] p1_level_out,
    output logic [2:0] p2_level_out
);
    // Outside drivers yield wherever the port drives, so no contention
    assign p1_level_out = (p1_pins_in.out & p1_pins_in.oe) | (p1_ext_in & ~p1_pins_in.oe);
    assign p2_level_out = (p2_pins_in.out & p2_pins_in.oe) | (p2_ext_in & ~p2_pins_in.oe);
endmodule

/* tb/dgp_port_pair_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module dgp_port_pair_tb;
    import dgp_pkg::*;
    logic clk_in = 0, rst_n_in = 0, cyc = 0, stb = 0, we = 0, sby = 0, ack;
    logic [9:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] wdat = '0, rdat;
    logic [1:0] dac_en = '0, dac_val = '0;
    logic [7:0] ext1 = '0, lvl1, din1, q, lat, dir, ana, cmp;
    logic [2:0] ext2 = '0, lvl2, din2;
    dgp_p1_pins_s p1p;
    dgp_p2_pins_s p2p;
    int mismatches = 0, comparisons = 0, i, b;
    dgp_port_pair DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .standby_pin_float_in(sby), .dac_enable_in(dac_en),
        .dac_value_in(dac_val), .p1_pin_in(lvl1), .p2_pin_in(lvl2), .p1_pins_out(p1p),
        .p2_pins_out(p2p), .p1_digital_in_out(din1), .p2_digital_in_out(din2));
    dgp_pin_model PINS (.p1_pins_in(p1p), .p2_pins_in(p2p), .p1_ext_in(ext1),
        .p2_ext_in(ext2), .p1_level_out(lvl1), .p2_level_out(lvl2));
    // ==========
    // Helpers
    function automatic logic [7:0] oe1(input logic [7:0] d);
        return d & ~(8'h01 << DGP_P1_IN_ONLY_BIT);
    endfunction
    function automatic logic [7:0] lv(input logic [7:0] l, input logic [7:0] o, input logic [7:0] e);
        return (l & o) | (e & ~o);
    endfunction
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // No fixed answer time assumed, only a bounded wait
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        `CHK(ack, 1'b1)
        if (ack !== 1'b1)
            stop_test();
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00, 4'h0);
        `CHK(q, e)
    endtask
    task automatic settle;
        repeat (5) @(posedge clk_in);
    endtask
    // ==========
    // Clock, watchdog, tests
    initial forever #5 clk_in = ~clk_in;
    initial
    begin
        #200000;
        mismatches++;
        stop_test();
    end
    initial
    begin
        void'($urandom(36920));
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        `CHK(p1p.oe, 8'h00)
        rd(DGP_IDX_P2_DIR, 8'h00);
        rd(DGP_IDX_ANA_EN, DGP_ENABLE_RST);
        rd(DGP_IDX_CMP_EN, DGP_ENABLE_RST);
        bus(1'b1, 8'h30, 8'hff, 4'h1);
        rd(8'h30, 8'h00);
        for (i = 0; i < 10; i++)
        begin
            lat = $urandom;
            dir = (i == 0) ? 8'hff : $urandom;
            ext1 <= $urandom;
            ext2 <= $urandom;
            bus(1'b1, DGP_IDX_P1_DATA, lat, 4'h1);
            bus(1'b1, DGP_IDX_P1_DIR, dir, 4'h1);
            bus(1'b1, DGP_IDX_P1_DATA, ~lat, 4'h0);
            bus(1'b1, DGP_IDX_P2_DATA, lat, 4'h1);
            bus(1'b1, DGP_IDX_P2_DIR, dir, 4'h1);
            settle();
            `CHK(p1p.oe, oe1(dir))
            `CHK(p1p.out & oe1(dir), lat & oe1(dir))
            `CHK(p2p.oe, dir[2:0])
            `CHK(p2p.out & dir[2:0], lat[2:0] & dir[2:0])
            rd(DGP_IDX_P1_DATA, lv(lat, oe1(dir), ext1));
            // Only three pins exist, so the upper read bits stay zero
            q = lv({5'h00, lat[2:0]}, {5'h00, dir[2:0]}, {5'h00, ext2});
            rd(DGP_IDX_P2_DATA, q);
            rd(DGP_IDX_P2_DIR, {5'h00, dir[2:0]});
        end
        // Pins read low, so a pin-based modify would lose latch bits
        ext1 <= 8'h00;
        bus(1'b1, DGP_IDX_P1_DIR, 8'h00, 4'h1);
        lat = $urandom;
        bus(1'b1, DGP_IDX_P1_DATA, lat, 4'h1);
        for (i = 0; i < 8; i++)
        begin
            b = $urandom % 8;
            q = $urandom % 2;
            // The bus task overwrites q, so the model is updated first
            lat[b] = q[0];
            bus(1'b1, DGP_IDX_BITOP, {q[0], 4'h0, b[2:0]}, 4'h1);
        end
        bus(1'b1, DGP_IDX_P1_DIR, 8'hff, 4'h1);
        settle();
        `CHK(p1p.out & 8'hef, lat & 8'hef)
        // Port two bit operations must leave port one alone
        bus(1'b1, DGP_IDX_P2_DATA, 8'h05, 4'h1);
        bus(1'b1, DGP_IDX_BITOP, 8'h89, 4'h1);
        bus(1'b1, DGP_IDX_BITOP, 8'h08, 4'h1);
        bus(1'b1, DGP_IDX_P2_DIR, 8'h07, 4'h1);
        settle();
        `CHK(p2p.out, 3'h6)
        `CHK(p1p.out & 8'hef, lat & 8'hef)
        bus(1'b1, DGP_IDX_P1_DIR, 8'h00, 4'h1);
        bus(1'b1, DGP_IDX_P2_DIR, 8'h00, 4'h1);
        for (i = 0; i < 4; i++)
        begin
            ana = (i == 0) ? 8'h00 : $urandom;
            cmp = (i == 0) ? 8'h00 : $urandom;
            ext1 <= $urandom;
            ext2 <= $urandom;
            bus(1'b1, DGP_IDX_ANA_EN, ana, 4'h1);
            bus(1'b1, DGP_IDX_CMP_EN, cmp, 4'h1);
            settle();
            `CHK(din1, ext1 & ~(ana | cmp))
            `CHK(din2, ext2 & {2'b11, ~ana[0]})
        end
        bus(1'b1, DGP_IDX_P1_DIR, 8'hff, 4'h1);
        bus(1'b1, DGP_IDX_P2_DIR, 8'h07, 4'h1);
        sby <= 1'b1;
        settle();
        `CHK(p1p.oe, 8'h00)
        `CHK(p2p.oe, 3'h0)
        `CHK(din1 & 8'hef, {8{DGP_STANDBY_IN_LEVEL}} & 8'hef)
        `CHK(din1[4], ext1[4] & ~(ana[4] | cmp[4]))
        `CHK(din2, {3{DGP_STANDBY_IN_LEVEL}})
        sby <= 1'b0;
        bus(1'b1, DGP_IDX_P2_DIR, 8'h00, 4'h1);
        for (i = 0; i < 4; i++)
        begin
            dac_en <= i[1:0];
            dac_val <= $urandom;
            settle();
            `CHK(p2p.oe[2:1], dac_en)
            `CHK(p2p.out[2:1] & dac_en, dac_val & dac_en)
        end
        stop_test();
    end
endmodule
